// ---- hdl/ocs_pkg.sv ----
/*
  Shared constants for the oscillator clock-source switch: register offsets,
  field positions, reset values, source codes and switch-state type.
  Assumes a 32-bit APB register bus with byte addresses.
*/
package ocs_pkg;

  // register byte offsets
  localparam logic [7:0] OCS_CTRL_ADDR = 8'h00; // source, frequency, range, request, engaged
  localparam logic [7:0] OCS_TRIM_ADDR = 8'h04; // internal oscillator period trim
  localparam logic [7:0] OCS_CFG_ADDR = 8'h08; // run-in-stop and output-pin clock enable

  // control register fields
  localparam int OCS_SRC_LSB = 6; // clock_source_select [7:6]
  localparam int OCS_IFS_LSB = 4; // internal_freq_select [5:4]
  localparam int OCS_XR_LSB = 2; // crystal_range_select [3:2]
  localparam int OCS_REQ_BIT = 1; // ext_clock_request
  localparam int OCS_ENG_BIT = 0; // ext_clock_engaged, read only

  // configuration register fields
  localparam int OCS_RIS_BIT = 0; // run_in_stop_en
  localparam int OCS_OCE_BIT = 1; // outpin_clock_out_en

  // reset values
  localparam logic [1:0] OCS_SRC_RST = 2'h0; // internal oscillator
  localparam logic [1:0] OCS_IFS_RST = 2'h0; // 4.0 MHz source, 1.0 MHz bus
  localparam logic [1:0] OCS_XR_RST = 2'h0; // 8-32 MHz amplifier
  localparam logic [7:0] OCS_TRIM_RST = 8'h80; // mid-scale trim

  // clock source codes
  localparam logic [1:0] OCS_SRC_INT = 2'h0; // internal oscillator
  localparam logic [1:0] OCS_SRC_EXT = 2'h1; // external clock on input pin
  localparam logic [1:0] OCS_SRC_RC = 2'h2; // external rc
  localparam logic [1:0] OCS_SRC_XTAL = 2'h3; // crystal

  // internal frequency codes
  localparam logic [1:0] OCS_IFS_4M0 = 2'h0; // 4.0 MHz
  localparam logic [1:0] OCS_IFS_8M0 = 2'h1; // 8.0 MHz
  localparam logic [1:0] OCS_IFS_12M8 = 2'h2; // 12.8 MHz
  localparam logic [1:0] OCS_IFS_25M6 = 2'h3; // 25.6 MHz

  // rising edges of the new source seen before a switch
  localparam int OCS_SWITCH_EDGES = 2;

  // switch sequencer states
  typedef enum logic [1:0] {
    OCS_ST_INT,
    OCS_ST_ARM,
    OCS_ST_EXT,
    OCS_ST_BACK
  } ocs_state_t;

endpackage

// ---- hdl/ocs_sync.sv ----
/*
  Three-flop synchroniser with agreement filter for one clock-like pin level.
  Assumes the input toggles well below pclk/4 so that every level is seen.
*/
`timescale 1ns/1ps
module ocs_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // asynchronous level in
  input wire logic async_in,
  // filtered synchronous level out
  output logic level
);

  logic s1_reg, s2_reg, s3_reg, lvl_reg; // chain and filtered level
  logic lvl_next; // next filtered level

  // a change counts only once stages two and three agree
  always_comb begin
    lvl_next = lvl_reg;
    if (s2_reg == s3_reg) begin
      lvl_next = s3_reg;
    end
  end

  // stage one is read only by stage two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      lvl_reg <= 1'b0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign level = lvl_reg;

endmodule // ocs_sync

// ---- hdl/ocs_half_div.sv ----
/*
  Half-rate generator: toggles on every rising edge of the full-rate level.
  Assumes the full-rate level is already synchronous to pclk.
*/
`timescale 1ns/1ps
module ocs_half_div (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // full-rate level in
  input wire logic full_in,
  // half-rate level out, from a flop
  output logic half_out
);

  logic prev_reg, half_reg; // previous full level, half-rate level
  logic half_next; // next half-rate level

  // toggle on each full-rate rising edge
  always_comb begin
    half_next = half_reg;
    if (full_in && !prev_reg) begin
      half_next = ~half_reg;
    end
  end

  // register the edge tracker and the divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
      half_reg <= 1'b0;
    end else begin
      prev_reg <= full_in;
      half_reg <= half_next;
    end
  end

  assign half_out = half_reg;

endmodule // ocs_half_div

// ---- hdl/ocs_switch.sv ----
/*
  Oscillator clock-source switch: APB registers, glitch-free switch between
  the internal oscillator and an external source, pin sharing and stop control.
  Assumes the oscillator clocks and pin levels run well below pclk/4, and that
  the analog oscillators obey the enables, frequency, range and trim outputs.
*/
//
// Behaviour
// - full-rate clock follows the selected source
// - half-rate clock is full-rate divided by two
// - full-rate clock feeds system unit and watchdog
// - four internal frequencies, reset selects 4.0 MHz
// - eight-bit trim, larger value means longer period
// - source write claims input pin, crystal claims output
// - two external rising edges, then glitch-free switch
// - engaged bit set before internal oscillator stops
// - clearing source and request returns to internal
// - external mode uses input pin as full rate
// - external mode forces output clock enable clear
// - crystal mode ignores output clock enable
// - rc mode outputs clock only when enabled
// - internal mode releases the input pin
// - no interrupts and no clearable flags
// - runs in wait; in stop only if enabled
// - source field codes, reset selects internal
// - frequency field codes, reset 4.0 MHz
// - crystal range field codes, 11 reserved
// - stop enable disables oscillators unless overridden
`timescale 1ns/1ps
module ocs_switch #(
  parameter int SWITCH_EDGES = ocs_pkg::OCS_SWITCH_EDGES // edges seen before a switch
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // oscillator clocks and input pin level
  input wire logic internal_osc_clock,
  input wire logic rc_osc_clock,
  input wire logic crystal_osc_clock,
  input wire logic osc_input_pin_in,
  // stop control from the system unit
  input wire logic stop_mode_osc_enable,
  // clocks to system unit and watchdog
  output logic clk_full_rate,
  output logic clk_half_rate,
  output logic clk_watchdog,
  // analog oscillator controls
  output logic internal_osc_en,
  output logic rc_osc_en,
  output logic crystal_osc_en,
  output logic [1:0] internal_freq_select_out,
  output logic [1:0] crystal_range_select_out,
  output logic [7:0] period_trim_value_out,
  // pin sharing
  output logic osc_input_pin_claimed,
  output logic osc_output_pin_xtal_amp,
  output logic osc_output_pin_out,
  output logic osc_output_pin_oe
);
  import ocs_pkg::*;

  // elaboration check: at least one edge proves activity
  if (SWITCH_EDGES < 1 || SWITCH_EDGES > 7) begin : g_chk
    $error("SWITCH_EDGES out of range");
  end

  // synchronised oscillator levels
  logic int_lvl, rc_lvl, xtal_lvl, pin_lvl;
  ocs_sync u_sync_int (.pclk(pclk), .presetn(presetn), .async_in(internal_osc_clock),
    .level(int_lvl));
  ocs_sync u_sync_rc (.pclk(pclk), .presetn(presetn), .async_in(rc_osc_clock),
    .level(rc_lvl));
  ocs_sync u_sync_xtal (.pclk(pclk), .presetn(presetn), .async_in(crystal_osc_clock),
    .level(xtal_lvl));
  ocs_sync u_sync_pin (.pclk(pclk), .presetn(presetn), .async_in(osc_input_pin_in),
    .level(pin_lvl));

  // register state
  logic [1:0] src_reg, src_next; // clock_source_select
  logic [1:0] ifs_reg, ifs_next; // internal_freq_select
  logic [1:0] xr_reg, xr_next; // crystal_range_select
  logic req_reg, req_next; // ext_clock_request
  logic [7:0] trim_reg, trim_next; // period_trim_value
  logic ris_reg, ris_next; // run_in_stop_en
  logic oce_reg, oce_next; // outpin_clock_out_en
  logic [31:0] prdata_reg, prdata_next; // read data
  logic pready_reg, pready_next; // one wait state per access
  logic pslverr_reg, pslverr_next; // unmapped address

  // switch state
  ocs_state_t st_reg, st_next; // sequencer
  logic [2:0] cnt_reg, cnt_next; // rising edges seen
  logic [1:0] esrc_reg, esrc_next; // external source latched at arm
  logic sel_ext_reg, sel_ext_next; // full rate taken from external source
  logic eng_reg, eng_next; // ext_clock_engaged
  logic int_run_reg, int_run_next; // internal oscillator wanted
  logic int_prev_reg, ext_prev_reg; // previous levels for edge detect

  // output flops
  logic full_reg, full_next; // full-rate clock
  logic int_en_reg, rc_en_reg, xtal_en_reg; // oscillator enables
  logic int_en_next, rc_en_next, xtal_en_next;
  logic claim_reg, claim_next; // input pin used as clock
  logic amp_reg, amp_next; // output pin given to crystal
  logic opin_reg, opin_next; // output pin level
  logic oe_reg, oe_next; // output pin drive
  logic half_lvl; // half-rate level from divider

  // apb decode, taken on the edge where pready is seen high
  logic acc, wr;
  assign acc = psel && penable && pready_reg;
  assign wr = acc && pwrite;

  // external source level, chosen by the latched or written source code
  logic [1:0] ext_code;
  logic ext_lvl, ext_rise, int_rise, both_low, allow;
  assign ext_code = (st_reg == OCS_ST_INT) ? src_reg : esrc_reg;
  assign ext_lvl = (ext_code == OCS_SRC_EXT) ? pin_lvl :
                   (ext_code == OCS_SRC_RC) ? rc_lvl : xtal_lvl;
  assign ext_rise = ext_lvl && !ext_prev_reg;
  assign int_rise = int_lvl && !int_prev_reg;
  assign both_low = !ext_lvl && !int_lvl;
  assign allow = stop_mode_osc_enable || ris_reg;

  // register file: writes, reads and bus answer
  always_comb begin
    src_next = src_reg;
    ifs_next = ifs_reg;
    xr_next = xr_reg;
    req_next = req_reg;
    trim_next = trim_reg;
    ris_next = ris_reg;
    oce_next = oce_reg;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    pready_next = psel && penable && !pready_reg;
    if (wr) begin
      case (paddr)
        OCS_CTRL_ADDR: begin
          src_next = pwdata[OCS_SRC_LSB +: 2];
          ifs_next = pwdata[OCS_IFS_LSB +: 2];
          xr_next = pwdata[OCS_XR_LSB +: 2];
          req_next = pwdata[OCS_REQ_BIT];
        end
        OCS_TRIM_ADDR: trim_next = pwdata[7:0];
        OCS_CFG_ADDR: begin
          ris_next = pwdata[OCS_RIS_BIT];
          oce_next = pwdata[OCS_OCE_BIT];
        end
        default: ;
      endcase
    end
    // external mode holds the output clock enable clear
    if (src_next == OCS_SRC_EXT) begin
      oce_next = 1'b0;
    end
    // read data is captured when the wait state starts
    if (psel && penable && !pready_reg) begin
      prdata_next = 32'h0000_0000;
      pslverr_next = 1'b0;
      case (paddr)
        OCS_CTRL_ADDR: begin
          prdata_next[OCS_SRC_LSB +: 2] = src_reg;
          prdata_next[OCS_IFS_LSB +: 2] = ifs_reg;
          prdata_next[OCS_XR_LSB +: 2] = xr_reg;
          prdata_next[OCS_REQ_BIT] = req_reg;
          prdata_next[OCS_ENG_BIT] = eng_reg;
        end
        OCS_TRIM_ADDR: prdata_next[7:0] = trim_reg;
        OCS_CFG_ADDR: begin
          prdata_next[OCS_RIS_BIT] = ris_reg;
          prdata_next[OCS_OCE_BIT] = oce_reg;
        end
        default: pslverr_next = 1'b1; // unmapped: error, reads zero
      endcase
    end
  end

  // register the register file
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_reg <= OCS_SRC_RST;
      ifs_reg <= OCS_IFS_RST;
      xr_reg <= OCS_XR_RST;
      req_reg <= 1'b0;
      trim_reg <= OCS_TRIM_RST;
      ris_reg <= 1'b0;
      oce_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      src_reg <= src_next;
      ifs_reg <= ifs_next;
      xr_reg <= xr_next;
      req_reg <= req_next;
      trim_reg <= trim_next;
      ris_reg <= ris_next;
      oce_reg <= oce_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // switch sequencer; the mux only moves while both clocks sit low,
  // so no shortened high pulse can reach the full-rate clock
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    esrc_next = esrc_reg;
    sel_ext_next = sel_ext_reg;
    eng_next = eng_reg;
    int_run_next = int_run_reg;
    case (st_reg)
      OCS_ST_INT: begin
        cnt_next = 3'h0;
        // software is trusted to have waited for the source to settle
        if (req_reg && src_reg != OCS_SRC_INT) begin
          esrc_next = src_reg;
          st_next = OCS_ST_ARM;
        end
      end
      OCS_ST_ARM: begin
        if (!req_reg || src_reg != esrc_reg) begin
          st_next = OCS_ST_INT; // request withdrawn before the switch
        end else if (cnt_reg < 3'(SWITCH_EDGES)) begin
          if (ext_rise) begin
            cnt_next = cnt_reg + 3'h1;
          end
        end else if (both_low) begin
          sel_ext_next = 1'b1;
          eng_next = 1'b1;
          st_next = OCS_ST_EXT;
        end
      end
      OCS_ST_EXT: begin
        // internal oscillator stops one cycle after engaged is set
        int_run_next = 1'b0;
        cnt_next = 3'h0;
        if (src_reg == OCS_SRC_INT && !req_reg) begin
          int_run_next = 1'b1;
          st_next = OCS_ST_BACK;
        end
      end
      OCS_ST_BACK: begin
        if (cnt_reg < 3'(SWITCH_EDGES)) begin
          if (int_rise) begin
            cnt_next = cnt_reg + 3'h1;
          end
        end else if (both_low) begin
          sel_ext_next = 1'b0;
          eng_next = 1'b0;
          st_next = OCS_ST_INT;
        end
      end
      default: st_next = OCS_ST_INT;
    endcase
  end

  // output-side next values: clocks, enables and pin sharing
  logic xtal_mode;
  assign xtal_mode = (st_reg == OCS_ST_INT) ? (src_reg == OCS_SRC_XTAL) :
                     (esrc_reg == OCS_SRC_XTAL);
  always_comb begin
    full_next = sel_ext_reg ? ext_lvl : int_lvl;
    int_en_next = int_run_reg && allow;
    rc_en_next = allow && ext_code == OCS_SRC_RC && st_reg != OCS_ST_INT ||
                 allow && src_reg == OCS_SRC_RC;
    xtal_en_next = allow && xtal_mode;
    claim_next = (src_reg != OCS_SRC_INT) || sel_ext_reg;
    amp_next = xtal_mode;
    // the crystal owns the pin; otherwise the enable decides
    oe_next = !xtal_mode && oce_reg &&
              (src_reg == OCS_SRC_INT || src_reg == OCS_SRC_RC);
    opin_next = oe_next && full_next;
  end

  // register sequencer and output flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= OCS_ST_INT;
      cnt_reg <= 3'h0;
      esrc_reg <= OCS_SRC_RST;
      sel_ext_reg <= 1'b0;
      eng_reg <= 1'b0;
      int_run_reg <= 1'b1;
      int_prev_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
      full_reg <= 1'b0;
      int_en_reg <= 1'b1;
      rc_en_reg <= 1'b0;
      xtal_en_reg <= 1'b0;
      claim_reg <= 1'b0;
      amp_reg <= 1'b0;
      opin_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      esrc_reg <= esrc_next;
      sel_ext_reg <= sel_ext_next;
      eng_reg <= eng_next;
      int_run_reg <= int_run_next;
      int_prev_reg <= int_lvl;
      ext_prev_reg <= ext_lvl;
      full_reg <= full_next;
      int_en_reg <= int_en_next;
      rc_en_reg <= rc_en_next;
      xtal_en_reg <= xtal_en_next;
      claim_reg <= claim_next;
      amp_reg <= amp_next;
      opin_reg <= opin_next;
      oe_reg <= oe_next;
    end
  end

  // half-rate clock; the system unit halves it again for the bus
  ocs_half_div u_half (.pclk(pclk), .presetn(presetn), .full_in(full_reg),
    .half_out(half_lvl));

  // outputs; no interrupt output exists and no flag needs clearing
  assign clk_full_rate = full_reg;
  assign clk_watchdog = full_reg;
  assign clk_half_rate = half_lvl;
  assign internal_osc_en = int_en_reg;
  assign rc_osc_en = rc_en_reg;
  assign crystal_osc_en = xtal_en_reg;
  assign internal_freq_select_out = ifs_reg;
  assign crystal_range_select_out = xr_reg;
  assign period_trim_value_out = trim_reg;
  assign osc_input_pin_claimed = claim_reg;
  assign osc_output_pin_xtal_amp = amp_reg;
  assign osc_output_pin_out = opin_reg;
  assign osc_output_pin_oe = oe_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // full rate follows the selected level one cycle later
  full_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 clk_full_rate == $past(sel_ext_reg ? ext_lvl : int_lvl))
    else $error("full-rate clock does not follow the selected source");

  // half rate changes only after a full-rate rise
  half_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(clk_half_rate) |-> $past(full_reg, 1) && !$past(full_reg, 2))
    else $error("half-rate clock moved without a full-rate rise");

  // switch to external only after the edge count
  switch_edges_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(sel_ext_reg) |-> $past(cnt_reg) == 3'(SWITCH_EDGES) && !$past(ext_lvl))
    else $error("external switch before two edges or while high");

  // engaged first, internal oscillator stopped next
  engage_order_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(eng_reg) |-> int_run_reg ##1 !int_run_reg && eng_reg)
    else $error("internal oscillator stopped in wrong order");

  // external mode keeps the output clock enable clear
  ext_oce_a: assert property (@(posedge pclk) disable iff (!presetn)
    src_reg == OCS_SRC_EXT |-> !oce_reg ##1 !osc_output_pin_oe)
    else $error("output clock enable set in external mode");

  // crystal mode never drives the output pin
  xtal_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    xtal_mode |=> osc_output_pin_xtal_amp && !osc_output_pin_oe)
    else $error("output pin not dedicated to crystal");

  // internal selection releases the input pin
  pin_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    src_reg == OCS_SRC_INT && !sel_ext_reg |=> !osc_input_pin_claimed)
    else $error("input pin held in internal mode");

  // stop without override disables every oscillator
  stop_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !stop_mode_osc_enable && !ris_reg |=> !internal_osc_en && !rc_osc_en && !crystal_osc_en)
    else $error("oscillator running in stop");

  // return clears engaged only with the internal source in place
  return_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(eng_reg) |-> !sel_ext_reg && int_run_reg && $past(st_reg) == OCS_ST_BACK)
    else $error("engaged cleared before internal source drives");

endmodule // ocs_switch

// ---- verification/ocs_osc_model.sv ----
/*
  Model of the oscillators and the external clock source behind the switch.
  Assumes pclk at 250 MHz; every clock level it makes lasts four cycles or more.
*/
`timescale 1ns/1ps
module ocs_osc_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // enables from the switch and from the bench
  input wire logic int_en,
  input wire logic rc_en,
  input wire logic xt_en,
  input wire logic ext_run,
  // oscillator outputs and input pin level
  output logic int_clk,
  output logic rc_clk,
  output logic xt_clk,
  output logic pin
);
  logic [7:0] cnt_reg; // free-running divider shared by every source

  // one counter keeps the sources in a fixed ratio, so periods are exact
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // a stopped oscillator rests low, as a gated analog stage would
  assign int_clk = int_en & cnt_reg[3]; // 16-cycle period
  assign rc_clk = rc_en & cnt_reg[2]; // 8-cycle period
  assign xt_clk = xt_en & cnt_reg[4]; // 32-cycle period
  assign pin = ext_run & cnt_reg[2]; // external source, 8-cycle period
endmodule // ocs_osc_model

// ---- verification/ocs_switch_tb.sv ----
/*
  Self-checking bench for ocs_switch: APB tasks and source-switch sequences.
  Assumes ocs_osc_model drives the oscillator clocks and the input pin.
*/
`timescale 1ns/1ps
module ocs_switch_tb;
  import ocs_pkg::*;
  localparam logic [7:0] FTRIM = 8'h5a; // stand-in factory trim, arbitrary
  // bench-driven inputs
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stop_en = 1, ext_run = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  // design outputs and model clocks
  logic pready, pslverr, se, full, half, wdog, int_en, rc_en, xt_en, claim, amp, pout, poe;
  logic [1:0] ifs_o, xr_o;
  logic [7:0] trim_o;
  logic ic, rc, xc, pin;
  int num_errors = 0, n_checks = 0, n, i;

  always #2 pclk = ~pclk;

  ocs_osc_model osc (.pclk(pclk), .presetn(presetn), .int_en(int_en), .rc_en(rc_en),
    .xt_en(xt_en), .ext_run(ext_run), .int_clk(ic), .rc_clk(rc), .xt_clk(xc), .pin(pin));

  ocs_switch #(.SWITCH_EDGES(2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .internal_osc_clock(ic), .rc_osc_clock(rc),
    .crystal_osc_clock(xc), .osc_input_pin_in(pin), .stop_mode_osc_enable(stop_en),
    .clk_full_rate(full), .clk_half_rate(half), .clk_watchdog(wdog),
    .internal_osc_en(int_en), .rc_osc_en(rc_en), .crystal_osc_en(xt_en),
    .internal_freq_select_out(ifs_o), .crystal_range_select_out(xr_o),
    .period_trim_value_out(trim_o), .osc_input_pin_claimed(claim),
    .osc_output_pin_xtal_amp(amp), .osc_output_pin_out(pout), .osc_output_pin_oe(poe));

  // verdict and end of run, also reached when a wait runs out
  task report_and_stop;
    if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // wait whole cycles, then step past the edge so outputs have settled
  task cyc(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask

  // one APB transfer; the request stands until pready is seen high at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int j;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (j = 0; j < 16; j++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    if (j == 16) begin
      num_errors++;
      report_and_stop;
    end
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(0, a, 32'h0);
    chk(q, exp);
  endtask

  // poll the engaged bit until it reads v, bounded
  task waiteng(input logic v);
    int j;
    for (j = 0; j < 40; j++) begin
      apb(0, OCS_CTRL_ADDR, 32'h0);
      if (q[OCS_ENG_BIT] === v) break;
    end
    chk(q[OCS_ENG_BIT], v);
    if (j == 40) report_and_stop;
  endtask

  // cycles between two rises of the full-rate (h=0) or half-rate (h=1) clock
  task per(input bit h);
    int c, f;
    logic p, s;
    f = -1;
    p = 1'b1;
    for (c = 0; c < 300; c++) begin
      @(posedge pclk);
      s = h ? half : full;
      if (s === 1'b1 && p === 1'b0) begin
        if (f >= 0) break;
        f = c;
      end
      p = s;
    end
    n = c - f;
    if (c == 300) begin
      num_errors++;
      report_and_stop;
    end
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    // reset state, and an unmapped address refused
    rdc(OCS_CTRL_ADDR, 32'h0);
    rdc(OCS_TRIM_ADDR, {24'h0, OCS_TRIM_RST});
    rdc(8'h0c, 32'h0);
    chk(se, 1);
    chk(int_en, 1);
    chk(claim, 0);
    // internal source drives full rate; half rate is half of it
    per(0);
    chk(n, 16);
    per(1);
    chk(n, 32);
    repeat (20) begin
      cyc(1);
      chk(wdog, full);
    end
    // every frequency code and every crystal range code
    for (i = 0; i < 4; i++) begin
      apb(1, OCS_CTRL_ADDR, (i << OCS_IFS_LSB) | ((3 - i) << OCS_XR_LSB));
      cyc(2);
      chk(ifs_o, i);
      chk(xr_o, 3 - i);
    end
    // trim extremes pass to the oscillator unchanged
    for (i = 0; i < 2; i++) begin
      apb(1, OCS_TRIM_ADDR, i ? 32'hff : 32'h0);
      cyc(2);
      chk(trim_o, i ? 32'hff : 32'h0);
    end
    // rc: input pin claimed, output pin drives the clock only when enabled
    apb(1, OCS_CTRL_ADDR, {OCS_SRC_RC, 6'h0});
    apb(1, OCS_CFG_ADDR, 32'h2);
    cyc(2);
    chk({rc_en, claim, poe, amp}, 4'he);
    // the driven output pin carries the full-rate clock, edge for edge
    repeat (20) begin
      cyc(1);
      chk(pout, full);
    end
    apb(1, OCS_CFG_ADDR, 32'h0);
    cyc(2);
    chk({poe, pout}, 2'h0);
    // crystal: amplifier owns the output pin, enable bit has no effect
    apb(1, OCS_CFG_ADDR, 32'h2);
    apb(1, OCS_CTRL_ADDR, {OCS_SRC_XTAL, 6'h0});
    cyc(2);
    chk({xt_en, amp, poe}, 3'h6);
    // external clock: settle, request, engage, then the internal one stops
    apb(1, OCS_CTRL_ADDR, {OCS_SRC_EXT, 6'h0});
    ext_run <= 1;
    rdc(OCS_CFG_ADDR, 32'h0);
    cyc(64);
    apb(1, OCS_CTRL_ADDR, {OCS_SRC_EXT, 4'h0, 2'h2});
    waiteng(1);
    cyc(3);
    chk(int_en, 0);
    per(0);
    chk(n, 8);
    per(1);
    chk(n, 16);
    // back to internal: oscillator restarts before engaged clears
    apb(1, OCS_CTRL_ADDR, 32'h0);
    waiteng(0);
    chk(int_en, 1);
    per(0);
    chk(n, 16);
    ext_run <= 0;
    // stop mode halts the oscillator unless run-in-stop is set
    stop_en <= 0;
    cyc(3);
    chk(int_en, 0);
    apb(1, OCS_CFG_ADDR, 32'h1);
    cyc(3);
    chk(int_en, 1);
    // software copies the factory trim itself
    apb(1, OCS_TRIM_ADDR, {24'h0, FTRIM});
    rdc(OCS_TRIM_ADDR, {24'h0, FTRIM});
    report_and_stop;
  end
endmodule // ocs_switch_tb
